// ==== vme_map_consts.vh ====
// Overview of operation
// - One map entry per 1 MB page
// - Map entries are write-only, no read path
// - Entry: permit, modifier, address and data width
// - Address 32/24/16/modifier; data 32/16/8/three-byte
// - Entry fixes the two lowest VME address bits
// - Multiplexer disabled means data passes unswapped
// - Eight swap functions, each read and write map
// - Entry selects one swap function for region
// - Read map: eight nibbles naming board nibbles
// - Write map rearranges processor nibbles onto board
// - Map 0x76543210 gives identity transfer
// - Map 0x32103210 copies low half to both
// - One slave window entry per 64 KB region
// - Window value 2 enables, zero disables slave
// - Master enable on: only permitted regions accessed
// - Master enable off: all master accesses refused
`ifndef VME_MAP_CONSTS_VH
`define VME_MAP_CONSTS_VH

// Region map entry layout
`define ENTRY_W          12
`define ENTRY_PERMIT     11
`define ENTRY_MOD_HI     10
`define ENTRY_MOD_LO     9
`define ENTRY_AW_HI      8
`define ENTRY_AW_LO      7
`define ENTRY_LOW_HI     6
`define ENTRY_LOW_LO     5
`define ENTRY_DW_HI      4
`define ENTRY_DW_LO      3
`define ENTRY_FN_HI      2
`define ENTRY_FN_LO      0

// Address modifier choices
`define MOD_USER_DATA    2'h0
`define MOD_USER_PROG    2'h1
`define MOD_SUPER_DATA   2'h2
`define MOD_SUPER_PROG   2'h3

// Address width choices
`define AW_FROM_MOD      2'h0
`define AW_32            2'h1
`define AW_24            2'h2
`define AW_16            2'h3

// Data width choices
`define DW_32            2'h0
`define DW_16            2'h1
`define DW_8             2'h2
`define DW_THREE         2'h3

// Table geometry
`define MAP_IDX_W        12
`define WIN_IDX_W        16
`define FN_COUNT         8
`define FN_W             3

// Swap map values
`define MAP_IDENTITY     32'h76543210
`define MAP_LOW_TO_BOTH  32'h32103210

// Slave window entry values
`define WIN_ENABLE       2'h2
`define WIN_DISABLE      2'h0

`endif

// ==== vme_region_map_byte_swap.v ====
`timescale 1ns/1ps
`default_nettype none
`include "vme_map_consts.vh"

module vme_region_map_byte_swap (
    input  wire                    clk,
    input  wire                    rst_n,
    // Global controls
    input  wire                    master_enable,
    input  wire                    mux_enable,
    // Region map write port
    input  wire                    map_wr,
    input  wire [`MAP_IDX_W-1:0]   map_wr_index,
    input  wire [`ENTRY_W-1:0]     map_wr_data,
    // Swap function programming port
    input  wire                    fn_wr,
    input  wire [`FN_W-1:0]        fn_wr_sel,
    input  wire [31:0]             fn_wr_read_map,
    input  wire [31:0]             fn_wr_write_map,
    // Slave window write port
    input  wire                    win_wr,
    input  wire [`WIN_IDX_W-1:0]   win_wr_index,
    input  wire [1:0]              win_wr_data,
    // Processor master request
    input  wire                    cpu_req,
    input  wire [31:0]             cpu_addr,
    input  wire                    cpu_write,
    input  wire [31:0]             cpu_wdata,
    output reg                     cpu_refused,
    // Returned VME read data and its swapped form
    input  wire                    vme_rdata_valid,
    input  wire [31:0]             vme_rdata,
    output reg                     cpu_rdata_valid,
    output reg  [31:0]             cpu_rdata,
    // VME master cycle request
    output reg                     vme_start,
    output reg  [31:0]             vme_addr,
    output reg                     vme_write,
    output reg  [31:0]             vme_wdata,
    output reg  [1:0]              vme_modifier,
    output reg  [1:0]              vme_addr_width,
    output reg  [1:0]              vme_data_width,
    // VME slave decode
    input  wire                    slave_req,
    input  wire [31:0]             slave_addr,
    output reg                     slave_accept,
    output reg                     slave_reject
);

    // Write-only region map; no read port is provided
    reg [`ENTRY_W-1:0] region_map [0:(1<<`MAP_IDX_W)-1];
    // Slave window table
    reg [1:0]          slave_win  [0:(1<<`WIN_IDX_W)-1];
    // Swap function maps
    reg [31:0]         read_map   [0:`FN_COUNT-1];
    reg [31:0]         write_map  [0:`FN_COUNT-1];

    // Function chosen for the last started cycle, read or write
    reg [`FN_W-1:0]    read_fn;
    reg                read_mux_on;

    // Nibble steering: output nibble i takes input nibble sel[i]
    function [31:0] steer;
        input [31:0] data;
        input [31:0] sel;
        integer      i;
        reg   [2:0]  src;
        begin
            steer = 32'h00000000;
            for (i = 0; i < 8; i = i + 1) begin
                src = sel[4*i +: 3];
                steer[4*i +: 4] = data[4*src +: 4];
            end
        end
    endfunction

    // Address shaping by width; low two bits come from the entry
    function [31:0] shape_addr;
        input [31:0] addr;
        input [1:0]  width;
        input [1:0]  low;
        begin
            case (width)
                `AW_24:   shape_addr = {8'h00, addr[23:2], low};
                `AW_16:   shape_addr = {16'h0000, addr[15:2], low};
                `AW_32:   shape_addr = {addr[31:2], low};
                default:  shape_addr = {addr[31:2], low};
            endcase
        end
    endfunction

    // Current entry of the addressed page
    wire [`ENTRY_W-1:0] entry    = region_map[cpu_addr[31:20]];
    wire                permit   = entry[`ENTRY_PERMIT];
    wire [1:0]          mod_sel  = entry[`ENTRY_MOD_HI:`ENTRY_MOD_LO];
    wire [1:0]          aw_sel   = entry[`ENTRY_AW_HI:`ENTRY_AW_LO];
    wire [1:0]          low_bits = entry[`ENTRY_LOW_HI:`ENTRY_LOW_LO];
    wire [1:0]          dw_sel   = entry[`ENTRY_DW_HI:`ENTRY_DW_LO];
    wire [`FN_W-1:0]    fn_sel   = entry[`ENTRY_FN_HI:`ENTRY_FN_LO];

    // Global enable gates every per-region permit
    wire allow = master_enable & permit;

    // Write data as placed on the board bus
    wire [31:0] steered_wdata = mux_enable ?
                                steer(cpu_wdata, write_map[fn_sel]) :
                                cpu_wdata;

    wire [1:0] win_entry = slave_win[slave_addr[31:16]];

    // Table writes; large tables are cleared by software, not reset
    always @(posedge clk) begin
        if (map_wr) begin
            region_map[map_wr_index] <= map_wr_data;
        end
        if (win_wr) begin
            slave_win[win_wr_index] <= win_wr_data;
        end
    end

    // Swap maps start as identity so an unprogrammed function is harmless
    genvar g;
    generate
        for (g = 0; g < `FN_COUNT; g = g + 1) begin : fn_slot
            always @(posedge clk) begin
                if (!rst_n) begin
                    read_map[g]  <= `MAP_IDENTITY;
                    write_map[g] <= `MAP_IDENTITY;
                end else if (fn_wr && fn_wr_sel == g) begin
                    read_map[g]  <= fn_wr_read_map;
                    write_map[g] <= fn_wr_write_map;
                end
            end
        end
    endgenerate

    // Master request path
    always @(posedge clk) begin
        if (!rst_n) begin
            vme_start      <= 1'b0;
            cpu_refused    <= 1'b0;
            vme_addr       <= 32'h00000000;
            vme_write      <= 1'b0;
            vme_wdata      <= 32'h00000000;
            vme_modifier   <= `MOD_USER_DATA;
            vme_addr_width <= `AW_FROM_MOD;
            vme_data_width <= `DW_32;
            read_fn        <= 3'h0;
            read_mux_on    <= 1'b0;
        end else begin
            vme_start   <= cpu_req & allow;
            cpu_refused <= cpu_req & ~allow;
            if (cpu_req && allow) begin
                vme_addr       <= shape_addr(cpu_addr, aw_sel,
                                             low_bits);
                vme_write      <= cpu_write;
                vme_wdata      <= steered_wdata;
                vme_modifier   <= mod_sel;
                vme_addr_width <= aw_sel;
                vme_data_width <= dw_sel;
                read_fn        <= fn_sel;
                read_mux_on    <= mux_enable;
            end
        end
    end

    // Read data return, steered by the function of the started cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            cpu_rdata_valid <= 1'b0;
            cpu_rdata       <= 32'h00000000;
        end else begin
            cpu_rdata_valid <= vme_rdata_valid;
            if (vme_rdata_valid) begin
                if (read_mux_on) begin
                    cpu_rdata <= steer(vme_rdata,
                                       read_map[read_fn]);
                end else begin
                    cpu_rdata <= vme_rdata;
                end
            end
        end
    end

    // Slave window decode
    always @(posedge clk) begin
        if (!rst_n) begin
            slave_accept <= 1'b0;
            slave_reject <= 1'b0;
        end else begin
            slave_accept <= slave_req &
                            (win_entry == `WIN_ENABLE);
            slave_reject <= slave_req &
                            (win_entry != `WIN_ENABLE);
        end
    end

endmodule

`default_nettype wire

// ==== vme_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
// Slave board on the far side: answers each started read after dly cycles
module vme_far_side (
    input  wire logic        clk,
    input  wire logic [7:0]  dly,
    input  wire logic        vme_start,
    input  wire logic        vme_write,
    output var  logic        vme_rdata_valid = 1'b0,
    output var  logic [31:0] vme_rdata = 32'h0
);
    logic [7:0] cnt = 8'h0;
    always @(posedge clk) begin
        vme_rdata_valid <= 1'b0;
        // Released data bus toggles so no stale word looks valid
        vme_rdata <= ~vme_rdata;
        if (vme_start && !vme_write)
            cnt <= dly;
        else if (cnt != 8'h0)
            cnt <= cnt - 8'h1;
        if (cnt == 8'h1) begin
            vme_rdata_valid <= 1'b1;
            vme_rdata <= 32'h89abcdef;
        end
    end
endmodule
`default_nettype wire

// ==== vme_region_map_byte_swap_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module vme_map_checker (
    input wire logic        clk, rst_n, master_enable, mux_enable, cpu_req,
    input wire logic        cpu_refused, vme_start, vme_write, slave_req,
    input wire logic        vme_rdata_valid, cpu_rdata_valid,
    input wire logic        slave_accept, slave_reject,
    input wire logic [1:0]  vme_addr_width,
    input wire logic [31:0] cpu_addr, cpu_wdata, vme_addr, vme_wdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_refuse_when_off: assert property (cpu_req && !master_enable
        |=> cpu_refused && !vme_start) else $error("refusal missing");
    a_no_stray_start: assert property (!cpu_req
        |=> !vme_start && !cpu_refused) else $error("stray answer");
    a_attr_hold: assert property (!vme_start
        |-> $stable(vme_addr) && $stable(vme_wdata)) else $error("moved");
    a_addr_narrow: assert property (vme_start && vme_addr_width == 2'h3
        |-> vme_addr[31:16] == 16'h0 && ((vme_addr ^ $past(cpu_addr))
        & 32'h0000fffc) == 32'h0) else $error("narrow address wrong");
    a_addr_full: assert property (vme_start && vme_addr_width < 2'h2
        |-> ((vme_addr ^ $past(cpu_addr)) & 32'hfffffffc) == 32'h0)
        else $error("full address wrong");
    a_plain_write: assert property (vme_start && vme_write
        && !$past(mux_enable) |-> vme_wdata == $past(cpu_wdata))
        else $error("unswapped data altered");
    a_read_return: assert property (vme_rdata_valid
        |=> cpu_rdata_valid) else $error("read data not returned");
    a_slave_answer: assert property (slave_req
        |=> slave_accept != slave_reject) else $error("slave answer");
endmodule
bind vme_region_map_byte_swap vme_map_checker chk_u (.*);
`default_nettype wire

// ==== vme_region_map_byte_swap_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module vme_region_map_byte_swap_tb;
    typedef struct {logic [11:0] e; logic [31:0] a, d, xa, xd; logic mx;} row_t;
    logic        clk = 0, rst_n = 0, master_enable = 1, mux_enable = 0;
    logic        map_wr = 0, fn_wr = 0, win_wr = 0, cpu_req = 0, slave_req = 0;
    logic        cpu_write = 0, cpu_refused, cpu_rdata_valid, vme_start;
    logic        vme_write, slave_accept, slave_reject, vme_rdata_valid;
    logic [11:0] map_wr_index = '0, map_wr_data = '0;
    logic [2:0]  fn_wr_sel = '0;
    logic [15:0] win_wr_index = '0;
    logic [1:0]  win_wr_data = '0, vme_modifier, vme_addr_width, vme_data_width;
    logic [31:0] fn_wr_read_map = '0, fn_wr_write_map = '0, cpu_addr = '0;
    logic [31:0] cpu_wdata = '0, slave_addr = '0, vme_rdata, cpu_rdata;
    logic [31:0] vme_addr, vme_wdata;
    logic [7:0]  dly = 8'h1;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    row_t rows[5] = '{
        '{12'h8c0, 32'h12345678, 32'h11223344, 32'h1234567a, 32'h11223344, 1},
        '{12'hb2a, 32'h56789abc, 32'h01234567, 32'h00789abd, 32'h76543210, 1},
        '{12'h600, 32'h00100000, 32'hffffffff, 32'h00789abd, 32'h76543210, 1},
        '{12'hdf1, 32'h0000ff00, 32'haaaa5678, 32'h0000ff03, 32'h56785678, 1},
        '{12'he1a, 32'h7ff00004, 32'h01234567, 32'h7ff00004, 32'h01234567, 0}};
    vme_region_map_byte_swap dut_u (.*);
    vme_far_side far_u (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic [31:0] a, input logic w, input logic m,
                       input logic [31:0] d);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        cpu_write <= w;
        mux_enable <= m;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_req <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        req(a, 1'b0, 1'b1, '0);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (cpu_rdata_valid === 1'b1) break;
        end
        chk(cpu_rdata, exp);
    endtask
    task automatic sl(input logic [31:0] a, input logic [1:0] exp);
        @(posedge clk);
        slave_req <= 1'b1;
        slave_addr <= a;
        @(posedge clk);
        slave_req <= 1'b0;
        #1;
        chk(32'({slave_accept, slave_reject}), 32'(exp));
    endtask
    task automatic wr(input logic [2:0] f, input logic [11:0] pg, e,
                      input logic [31:0] r, w);
        @(posedge clk);
        {fn_wr, map_wr} <= {pg == 12'hfff, pg != 12'hfff};
        fn_wr_sel <= f;
        map_wr_index <= pg;
        map_wr_data <= e;
        fn_wr_read_map <= r;
        fn_wr_write_map <= w;
        @(posedge clk);
        {fn_wr, map_wr} <= 2'b00;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk(vme_addr, 32'h0);
        chk(32'({vme_start, cpu_refused, cpu_rdata_valid, slave_accept}), 0);
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 65536; i++) begin
            @(posedge clk);
            map_wr <= i < 4096;
            map_wr_index <= i[11:0];
            win_wr <= 1'b1;
            win_wr_index <= i[15:0];
        end
        @(posedge clk);
        {map_wr, win_wr} <= 2'b00;
        wr(3'h0, 12'hfff, '0, 32'h76543210, 32'h76543210);
        wr(3'h1, 12'hfff, '0, 32'h32103210, 32'h32103210);
        wr(3'h2, 12'hfff, '0, 32'h01234567, 32'h01234567);
        foreach (rows[i]) begin
            wr(3'h0, rows[i].a[31:20], rows[i].e, '0, '0);
            req(rows[i].a, 1'b1, rows[i].mx, rows[i].d);
            chk(32'({vme_start, cpu_refused}), {rows[i].e[11], !rows[i].e[11]});
            chk(vme_addr, rows[i].xa);
            chk(vme_wdata, rows[i].xd);
            chk(32'(vme_write), 32'h1);
            if (rows[i].e[11])
                chk(32'({vme_modifier, vme_addr_width, vme_data_width}), 32'({rows[i].e[10:7], rows[i].e[4:3]}));
        end
        rd(32'h0000ff00, 32'hcdefcdef);
        rd(32'h56789abc, 32'hfedcba98);
        dly <= 8'h6;
        rd(32'h12345678, 32'h89abcdef);
        @(posedge clk);
        master_enable <= 1'b0;
        req(32'h12345678, 1'b1, 1'b1, '0);
        chk(32'({vme_start, cpu_refused}), 32'h1);
        @(posedge clk);
        {win_wr, win_wr_index, win_wr_data} <= {1'b1, 16'h1234, 2'h2};
        @(posedge clk);
        {win_wr_index, win_wr_data} <= {16'h1235, 2'h1};
        @(posedge clk);
        win_wr <= 1'b0;
        sl(32'h1234abcd, 2'b10);
        sl(32'h12350000, 2'b01);
        sl(32'h12360000, 2'b01);
        print_verdict();
    end
endmodule
`default_nettype wire
